// ### rtl/wdc_watchdog.v
// watchdog control and status logic with register port
//
// Notes on behaviour
// R1: power-up flag bit 6 set at power-up; only software clears or writes it.
// R2: time-out sets interrupt flag bit 3 regardless of enable; software clears.
// R3: extended interrupt enable bit 4 gates the watchdog interrupt request.
// R4: with reset-enable set, watchdog reset sets reset flag bit 2; else untouched.
// R5: control bit 1 lets a time-out reset the device.
// R6: writing 1 to bit 0 restarts the count; hardware clears the bit.
// R7: external reset loads control with 0x0x0xx0b, x bits keep their value.
// R8: watchdog reset sets reset flag and leaves all other control bits.
// R9: power-on reset clears reset flag and reset-enable, sets power-up flag.
// R10: reads free; bits 6,3,1,0 written only under timed access.
// R11: timed access is AAh then 55h to the key register.
// R12: clock control upper bits both set select a 26-bit interval.
// R13: restart source bit 0 picks loader or application flash; timed access.
// R14: counter runs on system clock; time-out then reset delay if enabled.
`timescale 1ns/1ps
`include "wdc_consts.vh"

module wdc_watchdog (
  input wire i_clock, // system clock 100 MHz
  input wire i_rst_b, // power-on reset, active low
  input wire i_ext_rst, // external reset pin, asynchronous, active high
  input wire [7:0] i_addr, // register address
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  output reg [7:0] o_rdata, // read data, one cycle after strobe
  output reg o_wd_irq, // watchdog interrupt request to the core
  output reg o_irq, // block status interrupt level
  output reg o_wd_reset, // watchdog reset pulse to the system
  output reg o_boot_loader // restart from loader flash after watchdog reset
);

  // reset release and pin synchroniser
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  reg [2:0] ext_sync_reg;
  reg ext_level_reg;
  reg ext_level_d_reg;

  // registers
  reg [7:0] ctrl_reg;
  reg [7:0] restart_src_reg;
  reg [7:0] ext_ie_reg;
  reg [7:0] clk_ctrl_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [1:0] ta_state_reg;
  reg [2:0] ta_cnt_reg;
  reg [25:0] count_reg;
  reg [9:0] delay_reg;
  reg delay_run_reg;
  reg [3:0] pulse_reg;
  reg [7:0] rdata_next;

  localparam TA_IDLE = 2'h0;
  localparam TA_HALF = 2'h1;
  localparam TA_OPEN = 2'h2;

  // write decode
  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    input w;
    begin
      wr_hit = w && (a == target);
    end
  endfunction

  // interval end for the selected length
  function [25:0] limit_of;
    input [1:0] sel;
    begin
      case (sel)
        `WDC_SEL_17: limit_of = 26'h001FFFF;
        `WDC_SEL_20: limit_of = 26'h00FFFFF;
        `WDC_SEL_23: limit_of = 26'h07FFFFF;
        default: limit_of = 26'h3FFFFFF; // R12
      endcase
    end
  endfunction

  wire ta_open = (ta_state_reg == TA_OPEN);
  wire wr_ctrl = wr_hit(i_addr, `WDC_ADDR_CTRL, i_wr);
  wire wr_ta = wr_hit(i_addr, `WDC_ADDR_TA_KEY, i_wr);
  wire restart_req = wr_ctrl && ta_open && i_wdata[`WDC_BIT_RESTART]; // R6
  wire timeout = (count_reg == limit_of(clk_ctrl_reg[7:6])); // R14
  wire wd_fire = delay_run_reg && (delay_reg == 10'h000);
  wire ext_edge = ext_level_reg && !ext_level_d_reg;
  wire status_rd = i_rd && (i_addr == `WDC_ADDR_IRQ_STATUS);

  // reset release through two flip-flops
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // external reset pin: three stages, change counted when stages two and three agree
  // the filtered level idles low like the pin, so no false edge follows reset
  // only the rising edge acts; a held pin does not reapply the reset
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_reg <= 3'h0;
      ext_level_reg <= 1'b0;
      ext_level_d_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], i_ext_rst};
      if (ext_sync_reg[1] == ext_sync_reg[2]) begin
        ext_level_reg <= ext_sync_reg[2];
      end
      ext_level_d_reg <= ext_level_reg;
    end
  end

  // timed access key sequence, open for a few cycles after AAh then 55h
  // any other write between the two key bytes aborts the sequence
  // the first write after the second key byte uses the window and closes it,
  // so each protected write needs a fresh key sequence
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ta_state_reg <= TA_IDLE;
      ta_cnt_reg <= 3'h0;
    end else begin
      case (ta_state_reg)
        TA_IDLE: begin
          if (wr_ta && i_wdata == `WDC_KEY_FIRST) begin
            ta_state_reg <= TA_HALF; // R11
          end
        end
        TA_HALF: begin
          if (wr_ta) begin
            ta_state_reg <= (i_wdata == `WDC_KEY_SECOND) ? TA_OPEN : TA_IDLE; // R11
            ta_cnt_reg <= `WDC_TA_WINDOW;
          end else if (i_wr) begin
            ta_state_reg <= TA_IDLE;
          end
        end
        TA_OPEN: begin
          ta_cnt_reg <= ta_cnt_reg - 3'h1;
          if (i_wr || ta_cnt_reg == 3'h0) begin
            ta_state_reg <= TA_IDLE; // R11
          end
        end
        default: ta_state_reg <= TA_IDLE;
      endcase
    end
  end

  // watchdog counter and reset delay
  // the counter wraps at the selected interval and flags a time-out each time
  // a reset is armed only when reset-enable is set at the time-out edge
  // a keyed restart or an external reset cancels an armed reset
  // the reset pulse is stretched so the rest of the system sees it reliably
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 26'h0;
      delay_reg <= 10'h0;
      delay_run_reg <= 1'b0;
      pulse_reg <= 4'h0;
    end else begin
      if (restart_req || ext_edge || wd_fire) begin
        count_reg <= 26'h0; // R6
        delay_run_reg <= 1'b0;
      end else begin
        count_reg <= timeout ? 26'h0 : count_reg + 26'h1; // R14
        if (timeout && ctrl_reg[`WDC_BIT_RSTEN] && !delay_run_reg) begin
          delay_run_reg <= 1'b1; // R5
          delay_reg <= `WDC_RESET_DELAY;
        end else if (delay_run_reg) begin
          delay_reg <= delay_reg - 10'h1; // R14
        end
      end
      if (wd_fire) begin
        pulse_reg <= `WDC_RESET_PULSE;
      end else if (pulse_reg != 4'h0) begin
        pulse_reg <= pulse_reg - 4'h1;
      end
    end
  end

  // control and status register
  // an external reset keeps only bits 6, 4, 2 and 1 and clears the rest
  // protected bits follow a write only while the key window is open
  // hardware sets are written last, so a set beats a software clear in the same cycle
  // the restart bit never stores a one; the restart acts through restart_req
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 8'h40; // R9
    end else if (ext_edge) begin
      ctrl_reg <= ctrl_reg & `WDC_EXT_MASK; // R7
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[7] <= i_wdata[7]; // R10
        ctrl_reg[5:4] <= i_wdata[5:4]; // R10
        ctrl_reg[`WDC_BIT_RSTF] <= i_wdata[`WDC_BIT_RSTF]; // R4
        if (ta_open) begin
          ctrl_reg[`WDC_BIT_POR] <= i_wdata[`WDC_BIT_POR]; // R1
          ctrl_reg[`WDC_BIT_RSTEN] <= i_wdata[`WDC_BIT_RSTEN]; // R5
          ctrl_reg[`WDC_BIT_TOIF] <= i_wdata[`WDC_BIT_TOIF]; // R10
        end
      end
      ctrl_reg[`WDC_BIT_RESTART] <= 1'b0; // R6
      if (timeout) begin
        ctrl_reg[`WDC_BIT_TOIF] <= 1'b1; // R2
      end
      if (wd_fire && ctrl_reg[`WDC_BIT_RSTEN]) begin
        ctrl_reg[`WDC_BIT_RSTF] <= 1'b1; // R8
      end
    end
  end

  // restart source select
  // only a keyed write lands here, so a runaway program cannot move the restart
  // target; the other bits are stored but read back as zero
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      restart_src_reg <= 8'h00;
    end else begin
      if (wr_hit(i_addr, `WDC_ADDR_RESTART_SRC, i_wr) && ta_open) begin
        restart_src_reg <= i_wdata; // R13
      end
    end
  end

  // extended interrupt enable, a plain register
  // bit 4 gates the watchdog interrupt; the other bits belong to other blocks
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_ie_reg <= 8'h00;
    end else begin
      if (wr_hit(i_addr, `WDC_ADDR_EXT_IE, i_wr)) begin
        ext_ie_reg <= i_wdata; // R3
      end
    end
  end

  // clock control, a plain register
  // the top two bits pick the interval; a change takes effect on the next
  // compare, so a shorter interval chosen mid-count may wrap the counter first
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctrl_reg <= 8'h00;
    end else begin
      if (wr_hit(i_addr, `WDC_ADDR_CLK_CTRL, i_wr)) begin
        clk_ctrl_reg <= i_wdata; // R12
      end
    end
  end

  // status interrupt mask, same layout as the status register
  // bit 0 passes time-outs, bit 1 passes watchdog resets
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= 2'h0;
    end else begin
      if (wr_hit(i_addr, `WDC_ADDR_IRQ_MASK, i_wr)) begin
        irq_mask_reg <= i_wdata[1:0];
      end
    end
  end

  // sticky event status, cleared by a read; a new event wins
  // an event in the same cycle as the clearing read stays visible for the
  // next read, so software never loses an event
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg <= (status_rd ? 2'h0 : irq_status_reg) | {wd_fire, timeout};
    end
  end

  // read data mux
  always @* begin
    rdata_next = 8'h00;
    case (i_addr)
      `WDC_ADDR_CTRL: rdata_next = ctrl_reg; // R10
      `WDC_ADDR_RESTART_SRC: rdata_next = {7'h00, restart_src_reg[`WDC_BIT_LOADER]};
      `WDC_ADDR_EXT_IE: rdata_next = ext_ie_reg;
      `WDC_ADDR_CLK_CTRL: rdata_next = clk_ctrl_reg;
      `WDC_ADDR_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
      `WDC_ADDR_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // registered outputs
  // read data stands only in the cycle after a read strobe and is zero
  // otherwise; interrupt levels lag their sources by one cycle
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
      o_wd_irq <= 1'b0;
      o_irq <= 1'b0;
      o_wd_reset <= 1'b0;
      o_boot_loader <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
      o_wd_irq <= ctrl_reg[`WDC_BIT_TOIF] && ext_ie_reg[`WDC_BIT_WD_INTERRUPT_ENABLE]; // R3
      o_irq <= |(irq_status_reg & irq_mask_reg);
      o_wd_reset <= (pulse_reg != 4'h0);
      o_boot_loader <= restart_src_reg[`WDC_BIT_LOADER]; // R13
    end
  end

endmodule

// ### rtl/wdc_consts.vh
// constants for the watchdog control and status block
`ifndef WDC_CONSTS_VH
`define WDC_CONSTS_VH
`define WDC_ADDR_RESTART_SRC 8'hD7
`define WDC_ADDR_CTRL 8'hD8
`define WDC_ADDR_EXT_IE 8'hE8
`define WDC_ADDR_TA_KEY 8'hC7
`define WDC_ADDR_CLK_CTRL 8'h8E
`define WDC_ADDR_IRQ_STATUS 8'hF2
`define WDC_ADDR_IRQ_MASK 8'hF3
`define WDC_BIT_POR 6
`define WDC_BIT_TOIF 3
`define WDC_BIT_RSTF 2
`define WDC_BIT_RSTEN 1
`define WDC_BIT_RESTART 0
`define WDC_BIT_WD_INTERRUPT_ENABLE 4
`define WDC_BIT_LOADER 0
`define WDC_KEY_FIRST 8'hAA
`define WDC_KEY_SECOND 8'h55
`define WDC_TA_WINDOW 3'h3
`define WDC_SEL_17 2'h0
`define WDC_SEL_20 2'h1
`define WDC_SEL_23 2'h2
`define WDC_SEL_26 2'h3
`define WDC_RESET_DELAY 10'h200
`define WDC_RESET_PULSE 4'h8
`define WDC_EXT_MASK 8'h56
`endif

// ### sim/wdc_watchdog_monitor.sv
// port-level assertion checker for the watchdog control block
`timescale 1ns/1ps
`include "wdc_consts.vh"

module wdc_watchdog_monitor (
  input wire i_clock, // system clock
  input wire i_rst_b, // power reset, active low
  input wire i_ext_rst, // external reset pin
  input wire [7:0] i_addr, // register address
  input wire [7:0] i_wdata, // write data
  input wire i_wr, // write strobe
  input wire i_rd, // read strobe
  input wire [7:0] o_rdata, // read data
  input wire o_wd_irq, // watchdog interrupt request
  input wire o_irq, // status interrupt level
  input wire o_wd_reset, // watchdog reset pulse
  input wire o_boot_loader // loader restart select
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // addresses that the block answers
  wire mapped = i_addr == `WDC_ADDR_RESTART_SRC || i_addr == `WDC_ADDR_CTRL || i_addr == `WDC_ADDR_EXT_IE ||
    i_addr == `WDC_ADDR_TA_KEY || i_addr == `WDC_ADDR_CLK_CTRL || i_addr == `WDC_ADDR_IRQ_STATUS ||
    i_addr == `WDC_ADDR_IRQ_MASK;
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_irq_gate_off: assert property ((i_rd && i_addr == `WDC_ADDR_EXT_IE) ##1 !o_rdata[4] |-> !o_wd_irq)
    else $error("watchdog irq raised while disabled");
  a_irq_flag_off: assert property ((i_rd && i_addr == `WDC_ADDR_CTRL) ##1 !o_rdata[3] |-> !o_wd_irq)
    else $error("watchdog irq raised without flag");
  a_irq_both_on: assert property ((i_rd && i_addr == `WDC_ADDR_CTRL) ##1 o_rdata[3] ##1 (i_rd && i_addr ==
    `WDC_ADDR_EXT_IE) ##1 o_rdata[4] |-> o_wd_irq)
    else $error("watchdog irq missing with flag and enable");
  a_boot_copy: assert property ((i_rd && i_addr == `WDC_ADDR_RESTART_SRC) |=> o_boot_loader == o_rdata[0])
    else $error("loader select differs from restart source");
  a_boot_hold: assert property (!i_wr && !$past(i_wr) |=> $stable(o_boot_loader))
    else $error("loader select changed without write");
  a_reset_pulse: assert property ($rose(o_wd_reset) |-> o_wd_reset [*8] ##1 !o_wd_reset)
    else $error("watchdog reset pulse length wrong");
endmodule

// ### sim/testbench.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`include "wdc_consts.vh"

module testbench;
  logic i_clock = 1'b0, i_rst_b = 1'b0, i_ext_rst = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  wire [7:0] o_rdata;
  wire o_wd_irq, o_irq, o_wd_reset, o_boot_loader;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  // rows: key first, address, data, value read back
  localparam logic [24:0] ROWS [10] = '{{1'b0, 8'hD8, 8'h00, 8'h40}, {1'b0, 8'hD8, 8'h04, 8'h44},
    {1'b0, 8'hD8, 8'h0B, 8'h40}, {1'b1, 8'hD8, 8'h02, 8'h02}, {1'b1, 8'hD8, 8'h03, 8'h02},
    {1'b1, 8'hD8, 8'h0A, 8'h0A}, {1'b0, 8'hE8, 8'h10, 8'h10}, {1'b0, 8'hD7, 8'h01, 8'h00},
    {1'b1, 8'hD7, 8'h01, 8'h01}, {1'b0, 8'hF5, 8'h55, 8'h00}};
  wdc_watchdog dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ext_rst(i_ext_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wd_irq(o_wd_irq), .o_irq(o_irq),
    .o_wd_reset(o_wd_reset), .o_boot_loader(o_boot_loader));
  // 100 MHz clock
  always #5 i_clock = ~i_clock;
  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic key;
    wr(`WDC_ADDR_TA_KEY, `WDC_KEY_FIRST);
    wr(`WDC_ADDR_TA_KEY, `WDC_KEY_SECOND);
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(`WDC_ADDR_CTRL, 8'h40);
    rd(`WDC_ADDR_RESTART_SRC, 8'h00);
    foreach (ROWS[i]) begin
      if (ROWS[i][24]) key();
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16], ROWS[i][7:0]);
    end
    chk({7'h00, o_wd_irq}, 8'h01);
    chk({7'h00, o_boot_loader}, 8'h01);
    rd(`WDC_ADDR_CTRL, 8'h0A);
    rd(`WDC_ADDR_EXT_IE, 8'h10);
    // broken key sequence leaves protected bits alone
    wr(`WDC_ADDR_TA_KEY, `WDC_KEY_FIRST);
    wr(`WDC_ADDR_EXT_IE, 8'h00);
    wr(`WDC_ADDR_TA_KEY, `WDC_KEY_SECOND);
    wr(`WDC_ADDR_CTRL, 8'h40);
    rd(`WDC_ADDR_CTRL, 8'h0A);
    chk({7'h00, o_wd_irq}, 8'h00);
    // external reset keeps only the x positions
    key();
    wr(`WDC_ADDR_CTRL, 8'h4E);
    rd(`WDC_ADDR_CTRL, 8'h4E);
    i_ext_rst <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_ext_rst <= 1'b0;
    repeat (8) @(posedge i_clock);
    rd(`WDC_ADDR_CTRL, 8'h46);
    rd(`WDC_ADDR_IRQ_STATUS, 8'h00);
    wr(`WDC_ADDR_IRQ_MASK, 8'h03);
    rd(`WDC_ADDR_IRQ_MASK, 8'h03);
    chk({6'h00, o_irq, o_wd_reset}, 8'h00);
    // second power reset in mid-run
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd(`WDC_ADDR_CTRL, 8'h40);
    chk({7'h00, o_boot_loader}, 8'h00);
    end_sim();
  end
endmodule

bind wdc_watchdog wdc_watchdog_monitor u_mon (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ext_rst(i_ext_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wd_irq(o_wd_irq),
  .o_irq(o_irq), .o_wd_reset(o_wd_reset), .o_boot_loader(o_boot_loader));
